// ---- common/srw_pkg.sv ----
// Shared constants and types for the serial register-write command block.
// Assumes a 100 MHz system clock and an SPI link clock that stops between
// frames.
package srw_pkg;

    // System clock and self-timed write durations.
    localparam int CLK_PERIOD_NS                 = 10;
    localparam int WR_STATUS_TIME_NS             = 8000;
    localparam int nonvolatile_cfg_write_time_ns = 20000;
    // Least times round up to whole cycles.
    localparam int WR_STATUS_CYCLES =
        (WR_STATUS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NV_CFG_WRITE_CYCLES =
        (nonvolatile_cfg_write_time_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Command opcodes handled here.
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS   = 8'h05;
    localparam logic [7:0] OP_READ_FLAGS    = 8'h70;
    localparam logic [7:0] OP_WR_STATUS     = 8'h01;
    localparam logic [7:0] OP_WR_NV_CFG     = 8'hB1;
    localparam logic [7:0] OP_WR_VOL_CFG    = 8'h81;
    localparam logic [7:0] OP_WR_ENH_CFG    = 8'h61;
    localparam logic [7:0] OP_WR_EXT_ADDR   = 8'hC5;

    // Bit counts at which a frame may legally end, and the count ceiling.
    localparam logic [4:0] FRAME_OPCODE_BITS = 5'h08;
    localparam logic [4:0] FRAME_ONE_BITS    = 5'h10;
    localparam logic [4:0] FRAME_TWO_BITS    = 5'h18;
    localparam logic [4:0] FRAME_BITS_MAX    = 5'h1F;

    // Status and flag status field positions.
    localparam int         ST_WIP_BIT     = 0;
    localparam int         ST_WEL_BIT     = 1;
    localparam int         ST_PROTECT_BIT = 7;
    localparam logic [7:0] ST_WRITE_MASK  = 8'hFC;
    localparam int         FLAG_READY_BIT = 7;

    // Values after reset.
    localparam logic [7:0]  STATUS_RST    = 8'h00;
    localparam logic [15:0] NV_CFG_RST    = 16'hFFFF;
    localparam logic [7:0]  VOL_CFG_RST   = 8'hFB;
    localparam logic [7:0]  VOL_CFG_RSVD  = 8'h04;
    localparam logic [7:0]  ENH_CFG_RST   = 8'hFF;
    localparam logic [7:0]  EXT_ADDR_RST  = 8'h00;

    // Data line usage of the link.
    typedef enum logic [1:0] {
        PROTO_EXTENDED = 2'b00,
        PROTO_DUAL     = 2'b01,
        PROTO_QUAD     = 2'b10
    } srw_proto_t;

    // What the link side has seen of the current or last frame.
    typedef struct packed {
        logic [4:0]  bits;
        logic [7:0]  opcode;
        logic [15:0] data;
    } srw_frame_t;

    // Command engine states.
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } srw_state_t;

endpackage : srw_pkg

// ---- rtl/srw_sync.sv ----
// Two-flop level synchroniser, one stage pair per bit.
// Assumes its inputs are levels that stay put for several destination clocks.
module srw_sync #(
    parameter int          W       = 1,
    parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
    // Destination clock and reset.
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } srw_sync_state_t;

    srw_sync_state_t q;
    srw_sync_state_t next_q;

    // The first stage feeds only the second stage.
    always_comb begin
        next_q.meta   = i_async;
        next_q.stable = q.meta;
    end

    // Both stages reset to the idle level of the line.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= {RST_VAL[W-1:0], RST_VAL[W-1:0]};
        end else begin
            q <= next_q;
        end
    end

    assign o_sync = q.stable;

endmodule : srw_sync

// ---- rtl/srw_link_rx.sv ----
// Link-side receiver: counts bits of a frame, keeps opcode and data bits.
// Assumes the link clock only runs while chip select is low.
module srw_link_rx (
    // Link clock and framing.
    input  wire logic               i_sck,
    input  wire logic               i_cs_n,
    input  wire logic [3:0]         i_dq,
    // Line usage from the system side.
    input  wire logic [1:0]         i_proto,
    // Frame content, stable while chip select is high.
    output srw_pkg::srw_frame_t     o_frame
);

    srw_pkg::srw_frame_t q;
    srw_pkg::srw_frame_t next_q;
    logic                first;
    logic [1:0]          proto_s;
    logic [5:0]          sum;
    logic [4:0]          base;
    logic [15:0]         shifted;
    logic [7:0]          op_shift;
    logic [2:0]          step;

    // Line usage is static; the link clock has no reset of its own.
    srw_sync #(.W(2)) u_proto_sync (
        .i_clk   (i_sck),
        .i_rst   (1'b0),
        .i_async (i_proto),
        .o_sync  (proto_s)
    );

    // A raised select marks the next edge as the start of a new frame.
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            first <= 1'b1;
        end else begin
            first <= 1'b0;
        end
    end

    // One, two or four bits per rising edge, first bit most significant.
    always_comb begin
        next_q   = q;
        base     = first ? 5'h00 : q.bits;
        op_shift = first ? 8'h00 : q.opcode;
        shifted  = first ? 16'h0000 : q.data;
        unique case (srw_pkg::srw_proto_t'(proto_s))
            srw_pkg::PROTO_DUAL: begin
                step     = 3'd2;
                op_shift = {op_shift[5:0], i_dq[1:0]};
                shifted  = {shifted[13:0], i_dq[1:0]};
            end
            srw_pkg::PROTO_QUAD: begin
                step     = 3'd4;
                op_shift = {op_shift[3:0], i_dq[3:0]};
                shifted  = {shifted[11:0], i_dq[3:0]};
            end
            default: begin
                step     = 3'd1;
                op_shift = {op_shift[6:0], i_dq[0]};
                shifted  = {shifted[14:0], i_dq[0]};
            end
        endcase
        sum = {1'b0, base} + {3'b000, step};
        if (!i_cs_n) begin
            next_q.bits = (sum > {1'b0, srw_pkg::FRAME_BITS_MAX})
                        ? srw_pkg::FRAME_BITS_MAX : sum[4:0];
            // Opcode first, data bytes after it.
            if (base < srw_pkg::FRAME_OPCODE_BITS) begin
                next_q.opcode = op_shift;
                next_q.data   = 16'h0000;
            end else begin
                next_q.opcode = q.opcode;
                next_q.data   = shifted;
            end
        end
    end

    // Sampled on the rising link clock edge.
    always_ff @(posedge i_sck) begin
        q <= next_q;
    end

    assign o_frame = q;

endmodule : srw_link_rx

// ---- rtl/srw_regwrite.sv ----
// Register-write command engine of a serial flash: write enable gating,
// frame checking, self-timed status and nonvolatile configuration writes,
// immediate volatile writes and per-die flag polling.
// Assumes the host keeps chip select high for at least four system clocks
// between frames, and that the line usage input is static during frames.

// Operation
// - Register writes act only while the write enable latch is 1.
// - Nonvolatile configuration data arrives least significant byte first.
// - Opcode then data, on one, two or four lines by protocol.
// - A frame ending off its boundary is dropped; latch and flags kept.
// - Status and nonvolatile writes run self-timed, each its own time.
// - Status write changes bits 7 to 2 only.
// - Status protection bit with write-protect pin blocks status writes.
// - Write in progress reads 1 while a self-timed write runs.
// - Accepted status and nonvolatile writes clear the latch, protected or not.
// - Write in progress returns to 0 when the timed write ends.
// - Each flag status read steps to the next die's flags.
// - Every die sets its controller ready flag at completion.
// - Volatile configuration write takes effect at frame end, no busy.
// - Volatile configuration write keeps reserved bits unchanged.
// - Enhanced volatile and extended address writes are also decoded.
// - Write enable sets the latch; write disable clears it.
// - Flag status read is accepted at any time, even when busy.
// - Status read is accepted at any time, even when busy.
module srw_regwrite #(
    parameter int N_DIE          = 2,
    parameter int STATUS_CYCLES  = srw_pkg::WR_STATUS_CYCLES,
    parameter int NV_CFG_CYCLES  = srw_pkg::NV_CFG_WRITE_CYCLES,
    // Die pointer width, derived so the port list can use it.
    localparam int DIE_W         = (N_DIE > 1) ? $clog2(N_DIE) : 1
) (
    // System clock and reset.
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    // Link pins.
    input  wire logic               i_sck,
    input  wire logic               i_cs_n,
    input  wire logic [3:0]         i_dq,
    input  wire logic               i_wp_n,
    // Configuration.
    input  wire logic [1:0]         i_proto,
    // Register contents.
    output logic      [7:0]         o_status,
    output logic      [15:0]        o_nv_cfg,
    output logic      [7:0]         o_vol_cfg,
    output logic      [7:0]         o_enh_cfg,
    output logic      [7:0]         o_ext_addr,
    // Flag polling and progress.
    output logic      [7:0]         o_flag_status,
    output logic      [DIE_W-1:0]   o_flag_die,
    output logic                    o_all_ready,
    output logic                    o_busy,
    output logic                    o_hw_protected,
    // Per-frame outcome pulses.
    output logic                    o_cmd_done,
    output logic                    o_cmd_discard
);

    // Refuse settings the counters and pointer cannot serve.
    if (N_DIE < 1 || N_DIE > 16) begin : g_bad_die
        $error("N_DIE must lie between 1 and 16");
    end
    if (STATUS_CYCLES < 1 || STATUS_CYCLES > 65536 ||
        NV_CFG_CYCLES < 1 || NV_CFG_CYCLES > 65536) begin : g_bad_time
        $error("Write durations must lie between 1 and 65536 cycles");
    end

    typedef struct packed {
        srw_pkg::srw_state_t fsm;
        logic                cs_prev;
        logic                pend;
        srw_pkg::srw_frame_t frame;
        logic [15:0]         timer;
        logic [7:0]          status;
        logic [15:0]         nv_cfg;
        logic [7:0]          vol_cfg;
        logic [7:0]          enh_cfg;
        logic [7:0]          ext_addr;
        logic [N_DIE-1:0]    ready;
        logic [DIE_W-1:0]    die;
        logic [7:0]          flag_out;
        logic                all_ready;
        logic                hwp;
        logic                done;
        logic                discard;
    } srw_core_t;

    srw_core_t           q;
    srw_core_t           next_q;
    srw_pkg::srw_frame_t link_frame;
    logic [1:0]          pins_s;
    logic                cs_s;
    logic                wp_s;
    logic                busy;
    logic                wel;
    logic                frame_one;
    logic                frame_two;
    logic                frame_cmd;
    logic                may_write;

    // Link-facing receiver on its own clock.
    srw_link_rx u_link (
        .i_sck   (i_sck),
        .i_cs_n  (i_cs_n),
        .i_dq    (i_dq),
        .i_proto (i_proto),
        .o_frame (link_frame)
    );

    // Select and write-protect pins into the system clock; both idle high.
    srw_sync #(.W(2), .RST_VAL(32'h0000_0003)) u_pin_sync (
        .i_clk   (i_clk),
        .i_rst   (i_sys_rst),
        .i_async ({i_cs_n, i_wp_n}),
        .o_sync  (pins_s)
    );

    assign cs_s = pins_s[1];
    assign wp_s = pins_s[0];

    // Busy state, write enable latch, write gating and frame shape of the captured frame.
    assign busy      = (q.fsm == srw_pkg::ST_BUSY);
    assign wel       = q.status[srw_pkg::ST_WEL_BIT];
    assign frame_cmd = (q.frame.bits == srw_pkg::FRAME_OPCODE_BITS);
    assign frame_one = (q.frame.bits == srw_pkg::FRAME_ONE_BITS);
    assign frame_two = (q.frame.bits == srw_pkg::FRAME_TWO_BITS);
    assign may_write = wel && !busy;

    // Command decode at frame end, self-timed writes and flag upkeep.
    always_comb begin
        next_q         = q;
        next_q.cs_prev = cs_s;
        next_q.done    = 1'b0;
        next_q.discard = 1'b0;
        next_q.pend    = 1'b0;
        next_q.hwp     = q.status[srw_pkg::ST_PROTECT_BIT] && !wp_s;

        // The frame only counts once select is back high; the link words
        // are then frozen because the link clock has stopped.
        if (cs_s && !q.cs_prev) begin
            next_q.frame = link_frame;
            next_q.pend  = 1'b1;
        end

        // Self-timed write progress.
        if (busy) begin
            if (q.timer == 16'h0000) begin
                next_q.fsm                         = srw_pkg::ST_IDLE;
                next_q.status[srw_pkg::ST_WIP_BIT] = 1'b0;
                next_q.ready = {N_DIE{1'b1}};
                next_q.done  = 1'b1;
            end else begin
                next_q.timer = q.timer - 16'h0001;
            end
        end

        if (q.pend) begin
            unique case (q.frame.opcode)
                srw_pkg::OP_WRITE_ENABLE,
                srw_pkg::OP_WRITE_DISABLE: begin
                    if (frame_cmd && !busy) begin
                        next_q.status[srw_pkg::ST_WEL_BIT] =
                            (q.frame.opcode == srw_pkg::OP_WRITE_ENABLE);
                        next_q.done = 1'b1;
                    end else begin
                        next_q.discard = 1'b1;
                    end
                end
                srw_pkg::OP_READ_FLAGS: begin
                    // Each flag read moves on to the next die.
                    if (q.frame.bits >= srw_pkg::FRAME_OPCODE_BITS) begin
                        next_q.die = (q.die == DIE_W'(N_DIE - 1))
                                   ? '0 : q.die + 1'b1;
                    end
                end
                srw_pkg::OP_READ_STATUS: begin
                    // Served by the read path; nothing changes here.
                    next_q.discard = 1'b0;
                end
                srw_pkg::OP_WR_STATUS: begin
                    if (frame_one && may_write) begin
                        if (!q.hwp) begin
                            next_q.status[7:2] =
                                q.frame.data[7:2];
                        end
                        next_q.status[srw_pkg::ST_WEL_BIT] = 1'b0;
                        next_q.status[srw_pkg::ST_WIP_BIT] = 1'b1;
                        next_q.ready = '0;
                        next_q.timer = 16'(STATUS_CYCLES - 1);
                        next_q.fsm   = srw_pkg::ST_BUSY;
                    end else begin
                        next_q.discard = 1'b1;
                    end
                end
                srw_pkg::OP_WR_NV_CFG: begin
                    if (frame_two && may_write) begin
                        // First data byte is the low byte.
                        next_q.nv_cfg = {q.frame.data[7:0],
                                         q.frame.data[15:8]};
                        next_q.status[srw_pkg::ST_WEL_BIT] = 1'b0;
                        next_q.status[srw_pkg::ST_WIP_BIT] = 1'b1;
                        next_q.ready = '0;
                        next_q.timer = 16'(NV_CFG_CYCLES - 1);
                        next_q.fsm   = srw_pkg::ST_BUSY;
                    end else begin
                        next_q.discard = 1'b1;
                    end
                end
                srw_pkg::OP_WR_VOL_CFG: begin
                    if (frame_one && may_write) begin
                        next_q.vol_cfg =
                            (q.frame.data[7:0] & ~srw_pkg::VOL_CFG_RSVD) |
                            (q.vol_cfg & srw_pkg::VOL_CFG_RSVD);
                        next_q.status[srw_pkg::ST_WEL_BIT] = 1'b0;
                        next_q.done = 1'b1;
                    end else begin
                        next_q.discard = 1'b1;
                    end
                end
                srw_pkg::OP_WR_ENH_CFG,
                srw_pkg::OP_WR_EXT_ADDR: begin
                    if (frame_one && may_write) begin
                        if (q.frame.opcode == srw_pkg::OP_WR_ENH_CFG) begin
                            next_q.enh_cfg = q.frame.data[7:0];
                        end else begin
                            next_q.ext_addr = q.frame.data[7:0];
                        end
                        next_q.status[srw_pkg::ST_WEL_BIT] = 1'b0;
                        next_q.done = 1'b1;
                    end else begin
                        next_q.discard = 1'b1;
                    end
                end
                default: begin
                    // Commands outside this family are left to other logic.
                    next_q.discard = 1'b0;
                end
            endcase
        end

        // Flag view of the die that the next poll will read.
        next_q.flag_out = 8'h00;
        next_q.flag_out[srw_pkg::FLAG_READY_BIT] =
            next_q.ready[next_q.die];
        next_q.all_ready = &next_q.ready;
    end

    // Register the whole state; polling sees it from reset onward.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q           <= '0;
            q.fsm       <= srw_pkg::ST_IDLE;
            q.cs_prev   <= 1'b1;
            q.status    <= srw_pkg::STATUS_RST;
            q.nv_cfg    <= srw_pkg::NV_CFG_RST;
            q.vol_cfg   <= srw_pkg::VOL_CFG_RST;
            q.enh_cfg   <= srw_pkg::ENH_CFG_RST;
            q.ext_addr  <= srw_pkg::EXT_ADDR_RST;
            q.ready     <= {N_DIE{1'b1}};
            q.flag_out  <= 8'h80;
            q.all_ready <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from the state register.
    assign o_status       = q.status;
    assign o_nv_cfg       = q.nv_cfg;
    assign o_vol_cfg      = q.vol_cfg;
    assign o_enh_cfg      = q.enh_cfg;
    assign o_ext_addr     = q.ext_addr;
    assign o_flag_status  = q.flag_out;
    assign o_flag_die     = q.die;
    assign o_all_ready    = q.all_ready;
    assign o_busy         = busy;
    assign o_hw_protected = q.hwp;
    assign o_cmd_done     = q.done;
    assign o_cmd_discard  = q.discard;

endmodule : srw_regwrite

// ---- dv/srw_regwrite_asserts.sv ----
// Checker for the register-write engine, bound to its top module.
// Assumes only the engine's ports and a single system clock domain.
module srw_regwrite_asserts #(
    parameter int STATUS_CYCLES = 5,
    parameter int NV_CFG_CYCLES = 7
) (
    // Clock, reset and pins.
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_cs_n,
    input wire logic       i_wp_n,
    // Watched outputs.
    input wire logic [7:0] o_status,
    input wire logic [7:0] o_flag_status,
    input wire logic       o_all_ready,
    input wire logic       o_busy,
    input wire logic       o_hw_protected,
    input wire logic       o_cmd_done,
    input wire logic       o_cmd_discard
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    int busy_len;
    // Counts the busy run, so a long or short timer is caught at its end.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !o_busy) busy_len <= 0;
        else busy_len <= busy_len + 1;
    end
    AST_WIP_IS_BUSY: assert property (o_status[0] == o_busy)
        else $error("wip bit differs from busy");
    AST_BUSY_NOT_READY: assert property (
        o_busy |-> !o_all_ready && !o_flag_status[7])
        else $error("ready shown while busy");
    AST_START_WEL: assert property (
        $rose(o_busy) |-> $past(o_status[1]) && !o_status[1])
        else $error("timed write without latch or latch kept");
    AST_BUSY_LEN: assert property (
        $fell(o_busy) |-> busy_len == STATUS_CYCLES
                          || busy_len == NV_CFG_CYCLES)
        else $error("timed write length wrong");
    AST_END_DONE: assert property ($fell(o_busy) |-> ##[0:1] o_cmd_done)
        else $error("no done pulse at write end");
    AST_DISCARD_KEEPS: assert property (
        o_cmd_discard |-> $stable(o_status) && !o_cmd_done)
        else $error("discarded frame changed status");
    AST_DISCARD_FRAMED: assert property (
        o_cmd_discard |-> i_cs_n && $past(i_cs_n, 2))
        else $error("discard before select rose");
    AST_HW_OFF: assert property (i_wp_n [*5] |-> !o_hw_protected)
        else $error("protected with pin high");
    AST_HW_ON: assert property (
        !i_wp_n [*5] ##0 o_status[7] && $past(o_status[7])
        |-> o_hw_protected)
        else $error("not protected with pin low and bit set");
    // Main scenarios reached.
    COV_TIMED: cover property ($rose(o_busy));
    COV_DISCARD: cover property (o_cmd_discard);
    COV_PROT_WRITE: cover property (o_hw_protected && $rose(o_busy));
endmodule : srw_regwrite_asserts

bind srw_regwrite srw_regwrite_asserts #(
    .STATUS_CYCLES(STATUS_CYCLES),
    .NV_CFG_CYCLES(NV_CFG_CYCLES)
) i_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(i_cs_n),
    .i_wp_n(i_wp_n), .o_status(o_status), .o_flag_status(o_flag_status),
    .o_all_ready(o_all_ready), .o_busy(o_busy),
    .o_hw_protected(o_hw_protected), .o_cmd_done(o_cmd_done),
    .o_cmd_discard(o_cmd_discard)
);

// ---- dv/srw_host_model.sv ----
// Host model of the serial link: select, clock and data lines.
// Assumes callers space frames; the clock stands low between frames.
module srw_host_model (
    // Link pins toward the engine.
    output logic       o_sck,
    output logic       o_cs_n,
    output logic [3:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sck  = 1'b0;
        o_dq   = 4'h5;
        // A real rising select edge arms the receiver's frame-start flag.
        #1 o_cs_n = 1'b1;
    end
    // One frame, opcode then data, MSB first, 1, 2 or 4 bits per clock.
    // Select rises right after the last counted bit, so the bit count
    // decides whether the engine takes the frame.
    task automatic frame(input logic [7:0] op, input logic [15:0] d,
                         input int nb, input logic [1:0] pr);
        logic [23:0] w;
        int          st;
        w  = {op, d};
        st = (pr == 2'b10) ? 4 : ((pr == 2'b01) ? 2 : 1);
        o_cs_n = 1'b0;
        for (int i = 0; i < nb; i += st) begin
            // An all-zero frame holds every line low, so it reads as
            // opcode 00 whatever line usage the receiver still applies.
            if (op == 8'h00 && d == 16'h0000) o_dq = 4'h0;
            else if (st == 4) o_dq = w[23:20];
            else if (st == 2) o_dq = {~o_dq[3:2], w[23:22]};
            else o_dq = {~o_dq[3:1], w[23]};
            w = w << st;
            #16 o_sck = 1'b1;
            #16 o_sck = 1'b0;
        end
        #8 o_cs_n = 1'b1;
        o_dq = ~o_dq; // Released lines must not keep the last bit.
        #100;
    endtask : frame
endmodule : srw_host_model

// ---- dv/srw_regwrite_tb.sv ----
// Self-checking bench for the register-write engine.
// Assumes the host model drives the link; short timed-write counts.
module srw_regwrite_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_sys_rst, i_wp_n, sck, cs_n;
    logic        ready, busy, hwp, done, disc;
    logic [1:0]  i_proto;
    logic [3:0]  dq;
    logic [7:0]  status, vol, enh, ext, flags;
    logic [15:0] nv;
    logic [0:0]  die;
    int          miscompares, tests_run, n_done, n_disc;
    srw_host_model i_host (.o_sck(sck), .o_cs_n(cs_n), .o_dq(dq));
    srw_regwrite #(.N_DIE(2), .STATUS_CYCLES(200), .NV_CFG_CYCLES(300))
    i_dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sck(sck), .i_cs_n(cs_n),
        .i_dq(dq), .i_wp_n(i_wp_n), .i_proto(i_proto), .o_status(status),
        .o_nv_cfg(nv), .o_vol_cfg(vol), .o_enh_cfg(enh), .o_ext_addr(ext),
        .o_flag_status(flags), .o_flag_die(die), .o_all_ready(ready),
        .o_busy(busy), .o_hw_protected(hwp), .o_cmd_done(done),
        .o_cmd_discard(disc));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Pulse counters; a one-cycle pulse is missed by a level check.
    always @(posedge i_clk) begin
        if (done === 1'b1) n_done++;
        if (disc === 1'b1) n_disc++;
    end
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Sends one frame and checks how many done and discard pulses came.
    task automatic cmdx(input logic [7:0] op, input logic [15:0] d,
                        input int nb, input int dd, input int ds);
        int d0, s0;
        d0 = n_done;
        s0 = n_disc;
        i_host.frame(op, d, nb, i_proto);
        @(posedge i_clk);
        #1;
        check("done", 16'(n_done - d0), 16'(dd));
        check("discard", 16'(n_disc - s0), 16'(ds));
    endtask : cmdx
    task automatic wen;
        cmdx(8'h06, 16'h0000, 8, 1, 0);
    endtask : wen
    // Waits, bounded, for the timed write to end and its done pulse.
    task automatic idle;
        int d0;
        d0 = n_done;
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge i_clk);
        repeat (2) @(posedge i_clk);
        #1;
        check("end pulse", 16'(n_done - d0), 16'h0001);
    endtask : idle
    task automatic test_done;
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // A hang counts as a mismatch.
    initial begin
        #500_000;
        miscompares++;
        test_done();
    end
    initial begin
        {i_sys_rst, i_wp_n, i_proto, n_done, n_disc} = '0;
        {miscompares, tests_run} = '0;
        i_sys_rst = 1'b1;
        i_wp_n = 1'b1;
        repeat (8) @(posedge i_clk);
        #1 i_sys_rst = 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        check("status", status, 16'h0000);
        check("nv", nv, 16'hFFFF);
        check("vol", vol, 16'h00FB);
        check("enh", enh, 16'h00FF);
        check("ext", ext, 16'h0000);
        check("flags", flags, 16'h0080);
        cmdx(8'h81, 16'h0000, 16, 0, 1);
        check("vol", vol, 16'h00FB);
        wen();
        check("wel", status[1], 16'h0001);
        cmdx(8'h04, 16'h0000, 8, 1, 0);
        check("wel", status[1], 16'h0000);
        wen();
        cmdx(8'h81, 16'hFF00, 12, 0, 1);
        cmdx(8'h81, 16'hFF00, 24, 0, 1);
        check("wel", status[1], 16'h0001);
        cmdx(8'h81, 16'hFF00, 16, 1, 0);
        check("vol", vol, 16'h00FB);
        check("busy", busy, 16'h0000);
        // Line usage settles over a dummy all-zero frame, read as no-op.
        for (int p = 2; p >= 0; p--) begin
            i_proto = 2'(p);
            cmdx(8'h00, 16'h0000, 8, 0, 0);
            wen();
            cmdx(8'h61, {8'h5A ^ 8'(p), 8'h00}, 16, 1, 0);
            check("enh", enh, 16'(8'h5A ^ 8'(p)));
            wen();
            cmdx(8'hC5, {8'hC3 + 8'(p), 8'h00}, 16, 1, 0);
            check("ext", ext, 16'(8'hC3 + 8'(p)));
        end
        wen();
        cmdx(8'h01, 16'hA700, 16, 0, 0);
        check("status", status, 16'h00A5);
        check("flags", flags, 16'h0000);
        cmdx(8'h70, 16'h0000, 8, 0, 0);
        check("die", die, 16'h0001);
        cmdx(8'h05, 16'h0000, 8, 0, 0);
        check("status", status, 16'h00A5);
        cmdx(8'h06, 16'h0000, 8, 0, 1);
        idle();
        check("status", status, 16'h00A4);
        check("ready", {flags[7], ready}, 16'h0003);
        i_wp_n = 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
        check("hwp", hwp, 16'h0001);
        wen();
        cmdx(8'h01, 16'h0000, 16, 0, 0);
        check("status", status, 16'h00A5);
        idle();
        i_wp_n = 1'b1;
        wen();
        cmdx(8'h01, 16'h0000, 16, 0, 0);
        idle();
        check("status", status, 16'h0000);
        wen();
        cmdx(8'hB1, 16'h3412, 16, 0, 1);
        cmdx(8'hB1, 16'h3412, 24, 0, 0);
        check("busy", busy, 16'h0001);
        idle();
        check("nv", nv, 16'h1234);
        test_done();
    end
endmodule : srw_regwrite_tb
